// file: hdl/clk_pkg.sv
// constants, codes and types shared by the clock and power control block
//
// Summary of operation
// - pll multiplier codes 07..17h give x4 to x12
// - high osc selectable at 24, 32, 48 MHz
// - subclock stop cleared by power-on reset only
// - wait code 0 none, then 1024 doubling
// - wait counted in 4 MHz low osc ticks
// - clock out source codes 0-4 and 8
// - clock out divide by power of two
// - drive bit low below 10 MHz, high above
// - low osc trim unsigned, rising with code
// - four independent internal clock division ratios
// - each module clock stopped by own bit
// - four operating power control modes
// - sleep entered by register plus instruction, interrupt exits
// - sleep halts cpu only, flash keeps running
// - deep sleep halts cpu, ram, dma unit
// - deep sleep also halts flash, transfer controller
// - oscillators follow own enables, not power mode
// - halted units keep their register contents
package clk_pkg;

   // ********************************
   // register byte offsets
   // ********************************
   localparam logic [7:0] OFF_PLL   = 8'h00;
   localparam logic [7:0] OFF_SUB   = 8'h04;
   localparam logic [7:0] OFF_WAIT  = 8'h08;
   localparam logic [7:0] OFF_CKO   = 8'h0c;
   localparam logic [7:0] OFF_DRV   = 8'h10;
   localparam logic [7:0] OFF_TRIM  = 8'h14;
   localparam logic [7:0] OFF_DIV   = 8'h18;
   localparam logic [7:0] OFF_MSTOP = 8'h1c;
   localparam logic [7:0] OFF_PWR   = 8'h20;
   localparam logic [7:0] OFF_OSC   = 8'h24;
   localparam logic [7:0] OFF_STAT  = 8'h28;

   // ********************************
   // field positions
   // ********************************
   localparam int PLL_EN_BIT   = 0;
   localparam int PLL_MUL_LSB  = 8;
   localparam int PLL_MUL_MSB  = 13;
   localparam int CKO_SRC_LSB  = 8;
   localparam int CKO_SRC_MSB  = 11;
   localparam int CKO_DIV_LSB  = 12;
   localparam int CKO_DIV_MSB  = 14;
   localparam int CKO_EN_BIT   = 15;
   localparam int WAIT_MSB     = 4;
   localparam int TRIM_MSB     = 7;
   localparam int OPM_MSB      = 2;
   localparam int DEEP_SEL_BIT = 8;
   localparam int MAIN_EN_BIT  = 0;
   localparam int HIGH_EN_BIT  = 1;
   localparam int HFREQ_LSB    = 4;
   localparam int HFREQ_MSB    = 5;
   localparam int DIV_W        = 4;   // one nibble per internal clock

   // ********************************
   // codes and reset values
   // ********************************
   localparam logic [5:0] PLL_MUL_MIN  = 6'h07;  // x4
   localparam logic [5:0] PLL_MUL_MAX  = 6'h17;  // x12
   localparam logic [4:0] WAIT_MAX     = 5'h08;  // 131,072 ticks
   localparam logic [4:0] WAIT_NONE    = 5'h00;
   localparam logic [3:0] SRC_LOW      = 4'h0;
   localparam logic [3:0] SRC_HIGH     = 4'h1;
   localparam logic [3:0] SRC_MAIN     = 4'h2;
   localparam logic [3:0] SRC_SUB      = 4'h3;
   localparam logic [3:0] SRC_PLL      = 4'h4;
   localparam logic [3:0] SRC_TOUCH    = 4'h8;
   localparam logic [2:0] DIV_NONE     = 3'h0;
   localparam logic [1:0] HF_24        = 2'h0;
   localparam logic [1:0] HF_32        = 2'h1;
   localparam logic [1:0] HF_48        = 2'h2;
   localparam logic [2:0] OPM_HIGH     = 3'h0;
   localparam logic [2:0] OPM_MID      = 3'h2;
   localparam logic [2:0] OPM_MID2     = 3'h4;
   localparam logic [2:0] OPM_LOW      = 3'h6;
   localparam logic [7:0] TRIM_RST     = 8'h80;
   localparam logic [15:0] DIV_RST     = 16'h0000;

   // ********************************
   // timing, in low osc ticks of 0.25 us
   // ********************************
   localparam int          WAIT_W         = 18;
   localparam logic [17:0] PLL_WAIT_TICKS = 18'h00100;
   localparam logic [17:0] HI_WAIT_TICKS  = 18'h00100;

   // ********************************
   // low power state
   // ********************************
   typedef enum logic [2:0] {
      PS_RUN   = 3'b001,
      PS_SLEEP = 3'b010,
      PS_DEEP  = 3'b100
   } power_state_e;

endpackage

// file: hdl/osc_wait_counter.sv
// stabilisation wait counter for one oscillator
module osc_wait_counter
(
   // clock and reset
   input  wire  logic                       clk,
   input  wire  logic                       rst_n,
   // control
   input  wire  logic                       en,
   input  wire  logic                       tick,
   input  wire  logic [clk_pkg::WAIT_W-1:0] target,
   // status
   output logic                             stable
);

   logic [clk_pkg::WAIT_W-1:0] cnt;  // ticks seen since enable

   // count low osc ticks; restart whenever the oscillator is stopped
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt    <= '0;
         stable <= 1'b0;
      end
      else if (!en)
      begin
         cnt    <= '0;
         stable <= 1'b0;
      end
      else if (!stable)
      begin
         if (cnt >= target)
            stable <= 1'b1;
         else if (tick)
            cnt <= cnt + 18'h00001;
      end
   end

endmodule

// file: hdl/clock_divider.sv
// power of two divider for a sampled clock level
module clock_divider
(
   // clock and reset
   input  wire  logic       clk,
   input  wire  logic       rst_n,
   // source and setting
   input  wire  logic       en,
   input  wire  logic       src,
   input  wire  logic [2:0] div_sel,
   // divided level
   output logic             clk_out
);

   logic       src_q;  // last sampled source level
   logic [6:0] cnt;    // source rises in this half period

   // source must run below half of clk to be seen
   wire       rise = src & ~src_q;
   wire [2:0] sh   = div_sel - 3'h1;
   wire [6:0] last = (7'h01 << sh) - 7'h01;

   // toggle every 2^(code-1) rises, giving divide by 2^code
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         src_q   <= 1'b0;
         cnt     <= '0;
         clk_out <= 1'b0;
      end
      else
      begin
         src_q <= src;
         if (!en)
         begin
            cnt     <= '0;
            clk_out <= 1'b0;
         end
         else if (div_sel == clk_pkg::DIV_NONE)
            clk_out <= src;
         else if (rise)
         begin
            if (cnt == last)
            begin
               cnt     <= '0;
               clk_out <= ~clk_out;
            end
            else
               cnt <= cnt + 7'h01;
         end
      end
   end

endmodule

// file: hdl/clock_gen_and_low_power_ctrl.sv
// clock generation and low power control, apb register slave
module clock_gen_and_low_power_ctrl
#(
   parameter logic [17:0] WAIT_BASE_TICKS = 18'h00400  // ticks for wait code 1
)
(
   // apb clock and resets
   input  wire  logic        pclk,
   input  wire  logic        presetn,
   input  wire  logic        por_n,
   // apb request
   input  wire  logic        psel,
   input  wire  logic        penable,
   input  wire  logic        pwrite,
   input  wire  logic [7:0]  paddr,
   input  wire  logic [31:0] pwdata,
   // apb answer
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   // oscillator levels, sampled
   input  wire  logic        low_osc_tick,
   input  wire  logic        low_speed_osc,
   input  wire  logic        high_speed_osc,
   input  wire  logic        main_clk,
   input  wire  logic        sub_clk,
   input  wire  logic        pll_clk,
   input  wire  logic        touch_clk,
   // cpu events
   input  wire  logic        standby_instr,
   input  wire  logic        wake_irq,
   // oscillator control
   output logic              main_osc_en,
   output logic              high_osc_en,
   output logic [1:0]        high_osc_freq_sel,
   output logic              pll_en,
   output logic [5:0]        pll_multiplier_sel,
   output logic              main_osc_drive_sel,
   output logic [7:0]        low_osc_trim,
   output logic              subclock_stop,
   // gated clock levels
   output logic              main_clk_gated,
   output logic              high_clk_gated,
   output logic              pll_clk_gated,
   output logic              clock_output_pin,
   // division and module stop
   output logic [2:0]        core_clock_div,
   output logic [2:0]        peripheral_bus_clock_div,
   output logic [2:0]        converter_clock_div,
   output logic [2:0]        flash_interface_clock_div,
   output logic [31:0]       module_clock_stop,
   // power control
   output logic [2:0]        op_power_mode,
   output logic              cpu_halt,
   output logic              main_ram_bank_halt,
   output logic              dma_unit_halt,
   output logic              flash_halt,
   output logic              transfer_controller_halt,
   output logic              resume_irq
);

   // ********************************
   // decoding functions
   // ********************************

   // legal pll multiplier code
   function automatic logic pll_ok(input logic [5:0] c);
      pll_ok = (c >= clk_pkg::PLL_MUL_MIN) && (c <= clk_pkg::PLL_MUL_MAX);
   endfunction

   // legal clock out source code
   function automatic logic src_ok(input logic [3:0] c);
      src_ok = (c <= clk_pkg::SRC_PLL) || (c == clk_pkg::SRC_TOUCH);
   endfunction

   // legal operating power mode code
   function automatic logic opm_ok(input logic [2:0] c);
      opm_ok = (c == clk_pkg::OPM_HIGH) || (c == clk_pkg::OPM_MID)
            || (c == clk_pkg::OPM_MID2) || (c == clk_pkg::OPM_LOW);
   endfunction

   // wait length in ticks for a wait code
   function automatic logic [17:0] wait_ticks(input logic [4:0] c);
      logic [4:0] sh;
      sh = c - 5'h01;
      if (c == clk_pkg::WAIT_NONE)
         wait_ticks = '0;
      else
         wait_ticks = WAIT_BASE_TICKS << sh;
   endfunction

   // ********************************
   // register state
   // ********************************
   logic [4:0]   osc_wait_sel;          // main osc wait code
   logic [3:0]   clock_out_source_sel;  // clock out source
   logic [2:0]   clock_out_divide_sel;  // clock out ratio
   logic         clock_out_en;          // clock out pin enable
   logic         deep_sel;              // standby goes to deep sleep
   clk_pkg::power_state_e pstate;       // low power state
   clk_pkg::power_state_e next_pstate;  // next low power state
   logic [2:0]   stable;                // main, high, pll settled

   // ********************************
   // apb decode
   // ********************************
   wire setup   = psel & ~penable;
   wire wr      = psel & penable & pwrite & pready;
   wire h_pll   = paddr == clk_pkg::OFF_PLL;
   wire h_sub   = paddr == clk_pkg::OFF_SUB;
   wire h_wait  = paddr == clk_pkg::OFF_WAIT;
   wire h_cko   = paddr == clk_pkg::OFF_CKO;
   wire h_drv   = paddr == clk_pkg::OFF_DRV;
   wire h_trim  = paddr == clk_pkg::OFF_TRIM;
   wire h_div   = paddr == clk_pkg::OFF_DIV;
   wire h_mstop = paddr == clk_pkg::OFF_MSTOP;
   wire h_pwr   = paddr == clk_pkg::OFF_PWR;
   wire h_osc   = paddr == clk_pkg::OFF_OSC;
   wire h_stat  = paddr == clk_pkg::OFF_STAT;
   wire hit     = h_pll | h_sub | h_wait | h_cko | h_drv | h_trim
               | h_div | h_mstop | h_pwr | h_osc | h_stat;

   // incoming write fields
   wire [5:0] w_mul  = pwdata[clk_pkg::PLL_MUL_MSB:clk_pkg::PLL_MUL_LSB];
   wire [3:0] w_src  = pwdata[clk_pkg::CKO_SRC_MSB:clk_pkg::CKO_SRC_LSB];
   wire [2:0] w_cdiv = pwdata[clk_pkg::CKO_DIV_MSB:clk_pkg::CKO_DIV_LSB];
   wire [4:0] w_wait = pwdata[clk_pkg::WAIT_MSB:0];
   wire [2:0] w_opm  = pwdata[clk_pkg::OPM_MSB:0];
   wire [1:0] w_hf   = pwdata[clk_pkg::HFREQ_MSB:clk_pkg::HFREQ_LSB];

   // ********************************
   // read data selection
   // ********************************
   wire [31:0] r_pll  = {16'h0000, 2'h0, pll_multiplier_sel,
                         7'h00, pll_en};
   wire [31:0] r_cko  = {16'h0000, clock_out_en, clock_out_divide_sel,
                         clock_out_source_sel, 8'h00};
   wire [31:0] r_div  = {16'h0000, 1'b0, flash_interface_clock_div,
                         1'b0, converter_clock_div,
                         1'b0, peripheral_bus_clock_div,
                         1'b0, core_clock_div};
   wire [31:0] r_pwr  = {23'h000000, deep_sel, 5'h00, op_power_mode};
   wire [31:0] r_osc  = {26'h0000000, high_osc_freq_sel, 2'h0,
                         high_osc_en, main_osc_en};
   wire [31:0] r_stat = {26'h0000000, pstate, stable};
   wire [31:0] rd_mux =
        ({32{h_pll}}   & r_pll)
      | ({32{h_sub}}   & {31'h00000000, subclock_stop})
      | ({32{h_wait}}  & {27'h0000000, osc_wait_sel})
      | ({32{h_cko}}   & r_cko)
      | ({32{h_drv}}   & {31'h00000000, main_osc_drive_sel})
      | ({32{h_trim}}  & {24'h000000, low_osc_trim})
      | ({32{h_div}}   & r_div)
      | ({32{h_mstop}} & module_clock_stop)
      | ({32{h_pwr}}   & r_pwr)
      | ({32{h_osc}}   & r_osc)
      | ({32{h_stat}}  & r_stat);

   // ********************************
   // apb answer
   // ********************************

   // answer ready in the first access cycle, no wait states
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & ~hit;    // unmapped address
         if (setup)
            prdata <= pwrite ? '0 : rd_mux;
      end
   end

   // ********************************
   // control registers
   // ********************************

   // pll, oscillator and wait settings; bad codes are ignored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pll_en             <= 1'b0;
         pll_multiplier_sel <= clk_pkg::PLL_MUL_MIN;
         osc_wait_sel       <= clk_pkg::WAIT_NONE;
         main_osc_en        <= 1'b0;
         high_osc_en        <= 1'b0;
         high_osc_freq_sel  <= clk_pkg::HF_24;
      end
      else if (wr)
      begin
         if (h_pll)
         begin
            pll_en <= pwdata[clk_pkg::PLL_EN_BIT];
            if (pll_ok(w_mul))
               pll_multiplier_sel <= w_mul;
         end
         if (h_wait && (w_wait <= clk_pkg::WAIT_MAX))
            osc_wait_sel <= w_wait;
         if (h_osc)
         begin
            main_osc_en <= pwdata[clk_pkg::MAIN_EN_BIT];
            high_osc_en <= pwdata[clk_pkg::HIGH_EN_BIT];
            if (w_hf <= clk_pkg::HF_48)
               high_osc_freq_sel <= w_hf;
         end
      end
   end

   // clock out, drive, trim and division settings
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clock_out_source_sel <= clk_pkg::SRC_LOW;
         clock_out_divide_sel <= clk_pkg::DIV_NONE;
         clock_out_en         <= 1'b0;
         main_osc_drive_sel   <= 1'b0;
         low_osc_trim         <= clk_pkg::TRIM_RST;
         flash_interface_clock_div <= clk_pkg::DIV_RST[2:0];
      end
      else if (wr)
      begin
         if (h_cko)
         begin
            if (src_ok(w_src))
               clock_out_source_sel <= w_src;
            clock_out_divide_sel <= w_cdiv;
            clock_out_en <= pwdata[clk_pkg::CKO_EN_BIT];
         end
         if (h_drv)
            main_osc_drive_sel <= pwdata[0];
         if (h_trim)
            low_osc_trim <= pwdata[clk_pkg::TRIM_MSB:0];
         if (h_div)
            flash_interface_clock_div <= pwdata[14:12];
      end
   end

   // independent internal clock ratios
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         core_clock_div           <= clk_pkg::DIV_RST[2:0];
         peripheral_bus_clock_div <= clk_pkg::DIV_RST[2:0];
         converter_clock_div      <= clk_pkg::DIV_RST[2:0];
      end
      else if (wr && h_div)
      begin
         core_clock_div           <= pwdata[2:0];
         peripheral_bus_clock_div <= pwdata[6:4];
         converter_clock_div      <= pwdata[10:8];
      end
   end

   // per module stop bits and power mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         module_clock_stop <= '0;
         op_power_mode     <= clk_pkg::OPM_HIGH;
         deep_sel          <= 1'b0;
      end
      else if (wr)
      begin
         if (h_mstop)
            module_clock_stop <= pwdata;
         if (h_pwr)
         begin
            if (opm_ok(w_opm))
               op_power_mode <= w_opm;
            deep_sel <= pwdata[clk_pkg::DEEP_SEL_BIT];
         end
      end
   end

   // subclock stop survives every reset but power-on
   always_ff @(posedge pclk or negedge por_n)
   begin
      if (!por_n)
         subclock_stop <= 1'b0;
      else if (wr && h_sub)
         subclock_stop <= pwdata[0];
   end

   // ********************************
   // stabilisation waits
   // ********************************
   wire [2:0]  osc_on = {pll_en & stable[0], high_osc_en, main_osc_en};
   wire [17:0] tgt [3];
   assign tgt[0] = wait_ticks(osc_wait_sel);
   assign tgt[1] = clk_pkg::HI_WAIT_TICKS;
   assign tgt[2] = clk_pkg::PLL_WAIT_TICKS;

   // pll waits on a settled main clock, its input
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_wait
         osc_wait_counter u_wait
         (
            .clk    (pclk),
            .rst_n  (presetn),
            .en     (osc_on[gi]),
            .tick   (low_osc_tick),
            .target (tgt[gi]),
            .stable (stable[gi])
         );
      end
   endgenerate

   // ********************************
   // gated clocks and clock out
   // ********************************

   // block runt pulses until the source has settled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         main_clk_gated <= 1'b0;
         high_clk_gated <= 1'b0;
         pll_clk_gated  <= 1'b0;
      end
      else
      begin
         main_clk_gated <= main_clk & stable[0];
         high_clk_gated <= high_speed_osc & stable[1];
         pll_clk_gated  <= pll_clk & stable[2];
      end
   end

   // clock out source selection
   wire cko_src =
        (clock_out_source_sel == clk_pkg::SRC_LOW)   ? low_speed_osc
      : (clock_out_source_sel == clk_pkg::SRC_HIGH)  ? high_clk_gated
      : (clock_out_source_sel == clk_pkg::SRC_MAIN)  ? main_clk_gated
      : (clock_out_source_sel == clk_pkg::SRC_SUB)   ? sub_clk & ~subclock_stop
      : (clock_out_source_sel == clk_pkg::SRC_PLL)   ? pll_clk_gated
      : touch_clk;

   clock_divider u_cko
   (
      .clk     (pclk),
      .rst_n   (presetn),
      .en      (clock_out_en),
      .src     (cko_src),
      .div_sel (clock_out_divide_sel),
      .clk_out (clock_output_pin)
   );

   // ********************************
   // low power state machine
   // ********************************

   // enter on instruction, leave only on interrupt
   always_comb
   begin
      next_pstate = pstate;
      unique case (pstate)
         clk_pkg::PS_RUN:
            if (standby_instr)
               next_pstate = deep_sel ? clk_pkg::PS_DEEP
                                      : clk_pkg::PS_SLEEP;
         clk_pkg::PS_SLEEP,
         clk_pkg::PS_DEEP:
            if (wake_irq)
               next_pstate = clk_pkg::PS_RUN;
         default:
            next_pstate = clk_pkg::PS_RUN;
      endcase
   end

   wire next_sleep = next_pstate == clk_pkg::PS_SLEEP;
   wire next_deep  = next_pstate == clk_pkg::PS_DEEP;

   // halts freeze clocks only, so halted units keep their contents
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pstate                   <= clk_pkg::PS_RUN;
         cpu_halt                 <= 1'b0;
         main_ram_bank_halt       <= 1'b0;
         dma_unit_halt            <= 1'b0;
         flash_halt               <= 1'b0;
         transfer_controller_halt <= 1'b0;
         resume_irq               <= 1'b0;
      end
      else
      begin
         pstate   <= next_pstate;
         cpu_halt <= next_sleep | next_deep;
         main_ram_bank_halt       <= next_deep;
         dma_unit_halt            <= next_deep;
         flash_halt               <= next_deep;
         transfer_controller_halt <= next_deep;
         resume_irq <= (pstate != clk_pkg::PS_RUN)
                     & (next_pstate == clk_pkg::PS_RUN);
      end
   end

endmodule

// file: testbench/clk_ctrl_properties.sv
// assertion checker for the clock and power control block
module clk_ctrl_properties
(
   // clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // apb handshake
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   // cpu events
   input wire logic       standby_instr,
   input wire logic       wake_irq,
   // halts and resume
   input wire logic       cpu_halt,
   input wire logic       main_ram_bank_halt,
   input wire logic       dma_unit_halt,
   input wire logic       flash_halt,
   input wire logic       transfer_controller_halt,
   input wire logic       resume_irq,
   // pll code
   input wire logic [5:0] pll_multiplier_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // setup then answered access
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   a_ready_next: assert property (s_setup |=> s_access) else $error("late ready");
   a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
   a_pll_legal: assert property (pll_multiplier_sel >= clk_pkg::PLL_MUL_MIN
      && pll_multiplier_sel <= clk_pkg::PLL_MUL_MAX) else $error("bad pll code");
   a_sleep_entry: assert property (!cpu_halt && standby_instr |=> cpu_halt)
      else $error("no halt");
   a_wake_exit: assert property (cpu_halt && wake_irq |=> !cpu_halt && resume_irq)
      else $error("no wake");
   a_resume_cause: assert property (resume_irq |-> $past(cpu_halt) && !cpu_halt)
      else $error("stray resume");
   a_halt_held: assert property (cpu_halt && !wake_irq |=> $stable(flash_halt) && cpu_halt)
      else $error("halt lost");
   a_deep_all: assert property (flash_halt |-> cpu_halt && main_ram_bank_halt
      && dma_unit_halt && transfer_controller_halt) else $error("deep partial");
   a_sleep_flash: assert property (cpu_halt && !dma_unit_halt |-> !flash_halt
      && !main_ram_bank_halt && !transfer_controller_halt) else $error("sleep over");
endmodule
bind clock_gen_and_low_power_ctrl clk_ctrl_properties clk_ctrl_properties_inst (.*);

// file: testbench/tb_top.sv
// self-checking bench for the clock and power control block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // apb side and resets
   logic        pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, module_clock_stop, rdat;
   logic        pready, pslverr, rerr;
   // cpu events, bit 1 wake and bit 0 standby
   logic [1:0]  ev = 2'h0;
   wire         wake_irq = ev[1], standby_instr = ev[0];
   // slow oscillator levels and low osc tick
   logic [3:0]  cnt = 4'h0;
   wire         low_osc_tick = &cnt[1:0];
   wire         low_speed_osc = cnt[2], high_speed_osc = cnt[2], main_clk = cnt[3];
   wire         sub_clk = cnt[2], pll_clk = cnt[3], touch_clk = cnt[3];
   // observed outputs
   logic        main_osc_en, high_osc_en, pll_en, main_osc_drive_sel, subclock_stop;
   logic        main_clk_gated, high_clk_gated, pll_clk_gated, clock_output_pin;
   logic        cpu_halt, main_ram_bank_halt, dma_unit_halt, flash_halt;
   logic        transfer_controller_halt, resume_irq;
   logic [1:0]  high_osc_freq_sel;
   logic [5:0]  pll_multiplier_sel;
   logic [7:0]  low_osc_trim;
   logic [2:0]  core_clock_div, peripheral_bus_clock_div, converter_clock_div;
   logic [2:0]  flash_interface_clock_div, op_power_mode;
   wire  [31:0] halts = {26'h0, cpu_halt, main_ram_bank_halt, dma_unit_halt,
                         flash_halt, transfer_controller_halt, resume_irq};
   int          fail_count = 0, total_checks = 0;
   // wait code 1 shortened to 4 ticks to keep the run brief
   clock_gen_and_low_power_ctrl #(.WAIT_BASE_TICKS(18'h00004))
      clock_gen_and_low_power_ctrl_inst (.*);
   always #5 pclk = ~pclk;
   always @(posedge pclk) cnt <= cnt + 4'h1;
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: %h not %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until ready is sampled
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdat    = prdata;
      rerr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   // one-cycle event pulse, then settle to a falling edge
   task automatic pulse(input logic [1:0] v);
      @(posedge pclk);
      ev <= v;
      @(posedge pclk);
      ev <= 2'h0;
      @(negedge pclk);
   endtask
   // fields, codes and refusals of illegal codes
   task automatic t_regs;
      logic [3:0] srcs [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
      rd(8'h00, 32'h0000_0700);
      rd(8'h14, 32'h0000_0080);
      wr(8'h00, 32'h0000_1700);
      wr(8'h00, 32'h0000_1800);
      rd(8'h00, 32'h0000_1700);
      wr(8'h08, 32'h8);
      wr(8'h08, 32'h9);
      rd(8'h08, 32'h8);
      for (int i = 0; i < 6; i++)
      begin
         wr(8'h0c, {17'h0, 3'(i + 2), srcs[i], 8'h00});
         rd(8'h0c, {17'h0, 3'(i + 2), srcs[i], 8'h00});
      end
      wr(8'h0c, 32'h0500);
      rd(8'h0c, 32'h0800);
      wr(8'h10, 32'h1);
      rd(8'h10, 32'h1);
      wr(8'h14, 32'hff);
      rd(8'h14, 32'hff);
      rd(8'h18, 32'h0);
      wr(8'h18, 32'h4321);
      rd(8'h18, 32'h4321);
      chk({20'h0, core_clock_div, peripheral_bus_clock_div, converter_clock_div,
           flash_interface_clock_div}, 32'h29c);
      wr(8'h1c, 32'ha5a5_0ff0);
      rd(8'h1c, 32'ha5a5_0ff0);
      chk(module_clock_stop, 32'ha5a5_0ff0);
      for (int m = 0; m < 8; m += 2)
      begin
         wr(8'h20, 32'(m));
         rd(8'h20, 32'(m));
         chk({29'h0, op_power_mode}, 32'(m));
      end
      wr(8'h20, 32'h1);
      rd(8'h20, 32'h6);
      for (int f = 0; f < 4; f++)
      begin
         wr(8'h24, 32'(f) << 4);
         rd(8'h24, 32'(f < 3 ? f : 2) << 4);
      end
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      $display("t_regs done");
   endtask
   // sub-clock stop survives a plain reset
   task automatic t_sub;
      wr(8'h04, 32'h1);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      chk({31'h0, subclock_stop}, 32'h1);
      por_n <= 1'b0;
      @(posedge pclk);
      por_n <= 1'b1;
      chk({31'h0, subclock_stop}, 32'h0);
      $display("t_sub done");
   endtask
   // main osc gated until four low osc ticks have passed
   task automatic t_wait;
      wr(8'h08, 32'h1);
      wr(8'h24, 32'h1);
      rd(8'h28, 32'h8);
      chk({31'h0, main_clk_gated}, 32'h0);
      wr(8'h0c, 32'h8000);
      repeat (40) @(posedge pclk);
      rd(8'h28, 32'h9);
      rerr = clock_output_pin;
      repeat (4) @(posedge pclk);
      chk({31'h0, clock_output_pin}, {31'h0, ~rerr});
      $display("t_wait done");
   endtask
   // sleep and deep sleep, held, then left on an interrupt
   task automatic t_power;
      for (int d = 0; d < 2; d++)
      begin
         wr(8'h20, 32'(d) << 8);
         pulse(2'h1);
         repeat (4) @(negedge pclk);
         chk(halts, d ? 32'h3e : 32'h20);
         pulse(2'h2);
         chk(halts, 32'h01);
      end
      $display("t_power done");
   endtask
   // verdict
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      por_n   <= 1'b1;
      t_regs;
      t_sub;
      t_wait;
      t_power;
      report_and_stop;
   end
   // hang guard, far beyond the few hundred cycles expected
   initial
   begin
      #100000;
      fail_count++;
      report_and_stop;
   end
endmodule
